// >>> rtl/bus_service_request_status.sv
/*
 * Service request and status logic of the bus talker/listener:
 * meta message response, panel remote/local/lockout state, status byte,
 * request mask and SRQ. Assumes an upstream decoder that delivers one-cycle
 * message pulses already qualified by addressing, and a command parser
 * that pulses set_request_mask_cmd with its decoded argument.
 */
module bus_service_request_status
    import srq_status_pkg::*;
#(
    parameter int ERR_LOW_BITS  = ERR_LOW_W,
    parameter int ERR_HIGH_BITS = ERR_HIGH_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    // Meta message from the bus decoder
    input  wire logic                     msg_valid,
    input  wire logic [3:0]               msg_code,
    input  wire logic                     talk_addressed,
    input  wire logic                     status_sent,
    // Device-dependent command byte from the listener path
    input  wire logic                     dd_byte_valid,
    input  wire logic [7:0]               dd_byte,
    // Mask command from the parser
    input  wire logic                     set_request_mask_cmd,
    input  wire logic [7:0]               mask_arg,
    input  wire logic                     await_talk_address_mode,
    // Measurement side
    input  wire logic                     meas_done,
    input  wire logic                     data_taken,
    input  wire logic [ERR_LOW_BITS-1:0]  err_low_set,
    input  wire logic [ERR_HIGH_BITS-1:0] err_high_set,
    input  wire logic                     err_high_clr,
    input  wire logic                     failure_in,
    input  wire logic                     oscillator_missing,
    // Front panel
    input  wire logic                     panel_key_valid,
    input  wire logic [7:0]               panel_key,
    input  wire logic                     reset_local_key,
    // Outputs
    output logic                          srq_out,
    output logic [7:0]                    poll_status_byte,
    output logic                          serial_poll_active,
    output logic                          remote_mode,
    output logic                          lockout_active,
    output logic                          blank_display,
    output logic                          start_meas,
    output logic                          abort_io,
    output logic                          dd_cmd_valid,
    output logic [7:0]                    dd_cmd,
    output logic                          panel_cmd_valid,
    output logic [7:0]                    panel_cmd
);

    // Elaboration check: a group narrower than one bit has no storage at all
    if (ERR_LOW_BITS < 1 || ERR_HIGH_BITS < 1) begin : g_width_check
        $error("error group widths must be at least one");
    end

    // Panel state, mask, error groups and request bookkeeping
    panel_state_t                 state_reg;
    panel_state_t                 state_next;
    logic [7:0]                   request_enable_mask;
    logic [ERR_LOW_BITS-1:0]      err_low_reg;
    logic [ERR_HIGH_BITS-1:0]     err_high_reg;
    logic                         data_ready;
    logic                         rqs_reg;
    logic [7:0]                   live_status;
    logic                         request_pending;
    logic                         rqs_clear;
    logic                         data_set;
    logic                         data_clr;

    // Decoded one-cycle meta messages
    wire logic is_msg = msg_valid;
    wire logic m_trigger = is_msg && msg_code == MSG_TRIGGER;
    wire logic m_clear   = is_msg && msg_code == MSG_CLEAR;
    wire logic m_abort   = is_msg && msg_code == MSG_ABORT;

    // Panel control state; remote entry never touches settings
    // Lockout taken while local waits in lockout_active and bites once remote
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_LOCAL: begin
                if (is_msg && msg_code == MSG_REMOTE) begin
                    state_next = ST_REMOTE;
                end else if (is_msg && msg_code == MSG_LOCKOUT) begin
                    state_next = ST_LOCAL;          // Lockout armed, takes hold on remote
                end
            end
            ST_REMOTE: begin
                if (is_msg && (msg_code == MSG_LOCAL || msg_code == MSG_LOCAL_CLEAR_LOCKOUT_MSG)) begin
                    state_next = ST_LOCAL;
                end else if (is_msg && msg_code == MSG_LOCKOUT) begin
                    state_next = ST_LOCKED;
                end else if (reset_local_key && !lockout_active) begin
                    state_next = ST_LOCAL;          // Only key honoured in remote
                end
            end
            ST_LOCKED: begin
                // Reset/local key inert here
                if (is_msg && (msg_code == MSG_LOCAL || msg_code == MSG_LOCAL_CLEAR_LOCKOUT_MSG)) begin
                    state_next = ST_LOCAL;
                end
            end
            default: state_next = ST_LOCAL;
        endcase
    end

    // Panel state register; power-on lands in local
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_LOCAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lockout flag; plain local keeps it, only the clear-lockout message drops it
    // Abort leaves lockout alone; only the bus unlock message frees the key
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lockout_active <= 1'b0;
        end else if (is_msg && msg_code == MSG_LOCAL_CLEAR_LOCKOUT_MSG) begin
            lockout_active <= 1'b0;
        end else if (is_msg && msg_code == MSG_LOCKOUT) begin
            lockout_active <= 1'b1;
        end
    end

    // Remote indication registered for the outside
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            remote_mode <= 1'b0;
        end else begin
            remote_mode <= (state_next != ST_LOCAL);
        end
    end

    // Trigger and clear restart measurement; incoming SRQ message falls through
    // Separate strobes so display blanking and the gate restart can be wired apart
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            blank_display <= 1'b0;
            start_meas    <= 1'b0;
        end else begin
            blank_display <= m_trigger || m_clear;
            start_meas    <= m_trigger || m_clear;
        end
    end

    // Abort: drop talk/listen and partial data, parameters untouched
    // Talk and listen state lives upstream; this pulse tells it to drop both
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            abort_io <= 1'b0;
        end else begin
            abort_io <= m_abort;
        end
    end

    // Device-dependent bytes pass only in remote; aborted cycle drops them
    // Limitation: dd_cmd follows every byte; only the strobe is gated
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dd_cmd_valid <= 1'b0;
            dd_cmd       <= 8'h00;
        end else begin
            dd_cmd_valid <= dd_byte_valid && state_reg != ST_LOCAL && !m_abort;
            if (dd_byte_valid) begin
                dd_cmd <= dd_byte;
            end
        end
    end

    // Panel keys pass only in local; the reset/local key is handled above
    // A key pressed in remote is dropped, not queued for later
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            panel_cmd_valid <= 1'b0;
            panel_cmd       <= 8'h00;
        end else begin
            panel_cmd_valid <= panel_key_valid && state_reg == ST_LOCAL;
            if (panel_key_valid) begin
                panel_cmd <= panel_key;
            end
        end
    end

    // Mask register, full 0..255 stored, unused bits ignored when gating
    // A zero argument parks every source, as does the reset value
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            request_enable_mask <= MASK_RESET;
        end else if (set_request_mask_cmd) begin
            request_enable_mask <= mask_arg;
        end
    end

    // Low errors cleared by the clear message; high errors and failures kept
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            err_low_reg <= '0;
        end else begin
            err_low_reg <= (m_clear ? '0 : err_low_reg) | err_low_set;
        end
    end

    // High errors survive a clear; only the panel reset drops them, a new one wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            err_high_reg <= '0;
        end else begin
            err_high_reg <= (err_high_clr ? '0 : err_high_reg) | err_high_set;
        end
    end

    // Data ready: posted when talk-addressed or in await mode; restart clears it
    // Limitation: untalked without await mode, a finished reading never posts data ready
    assign data_set = meas_done && (talk_addressed || await_talk_address_mode);
    assign data_clr = data_taken || m_trigger || m_clear;

    // Set wins, so a reading that lands as the last one is taken still shows
    sticky_flag u_data_ready (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .set_pulse (data_set),
        .clr_pulse (data_clr),
        .flag      (data_ready)
    );

    // Live conditions, independent of mask; bits 7 and 1 fixed low
    // Failure drives its own bit and mask position, apart from the error group
    always_comb begin
        live_status               = 8'h00;
        live_status[BIT_DATA_READY] = data_ready;
        live_status[BIT_ERROR]    = |{err_low_reg, err_high_reg};
        live_status[BIT_FAILURE]  = failure_in;
        live_status[BIT_LOCAL]    = (state_reg == ST_LOCAL);
        live_status[BIT_OSCILLATOR_MISSING]   = oscillator_missing;
    end

    // Bit 6 and unused bits never enable a source
    // Clear only counts while polling, so a stray status_sent does nothing
    assign request_pending = |(live_status & request_enable_mask & MASK_USED_BITS);
    assign rqs_clear       = serial_poll_active && status_sent;

    // Request latch; a pending condition re-raises after the poll releases it
    // Level-sensitive: a condition that predates the mask still requests once enabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rqs_reg <= 1'b0;
        end else if (rqs_clear) begin
            rqs_reg <= 1'b0;
        end else if (!request_pending) begin
            rqs_reg <= 1'b0;
        end else if (!rqs_reg && request_pending) begin
            rqs_reg <= 1'b1;
        end
    end

    // Held request state blocks re-raise until the condition drops
    // Without it the latch would raise SRQ again at once and the poll would loop
    logic served_reg;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            served_reg <= 1'b0;
        end else if (rqs_clear) begin
            served_reg <= 1'b1;
        end else if (!request_pending) begin
            served_reg <= 1'b0;
        end
    end

    // Status byte and SRQ refreshed every cycle, readable at any poll
    // One edge behind the live conditions; a poll sees the previous cycle's view
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            poll_status_byte <= 8'h00;
            srq_out          <= 1'b0;
        end else begin
            poll_status_byte <= live_status | {1'b0, rqs_reg && !served_reg, 6'h00};
            srq_out          <= rqs_reg && !served_reg && !rqs_clear;
        end
    end

    // Serial poll mode: status byte replaces data when talking
    // Abort also ends a poll, since the controller gives up the talker
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_poll_active <= 1'b0;
        end else if (m_abort || (is_msg && msg_code == MSG_SPD)) begin
            serial_poll_active <= 1'b0;
        end else if (is_msg && msg_code == MSG_SPE) begin
            serial_poll_active <= 1'b1;
        end
    end

endmodule

// >>> rtl/srq_status_pkg.sv
/*
 * Constants for the bus service-request and status block: status byte
 * field positions, mask layout, meta message codes and reset values.
 * Assumes a single 25 MHz instrument clock and an upstream bus decoder.
 */
// Summary of operation
// - Trigger blanks the display and starts a new measurement at once.
// - Clear blanks, restarts, clears errors 1.0-4.4, keeps errors 5.x and failures.
// - In remote only the reset/local key works; programming comes from the bus.
// - Going remote leaves every measurement setting as it was.
// - Local returns control to the panel and keeps all settings.
// - In local the device drops all device-dependent command bytes.
// - After lockout the reset/local key is inert until a local-and-clear-lockout message.
// - Local-and-clear-lockout returns to panel control, other state unchanged.
// - A received service request message does nothing.
// - Abort stops talk and listen, drops partial data, keeps parameters.
// - Request sources: data ready, error or failure, no oscillator, local.
// - Mask-set command loads its binary argument into the mask register.
// - SRQ and RQS assert only when a status bit and its mask bit agree.
// - A zero mask disables every request source.
// - A mask of only bit 6 behaves as a zero mask.
// - Mask accepts 0 to 255; only bits 5,4,3,2,0 take effect.
// - Status bits show live conditions regardless of the mask.
// - Status byte is eight bits; bits 7 and 1 always read zero.
// - Weights: RQS 64, no oscillator 32, local 16, failure 8, error 4, data 1.
// - The status byte is available whenever the controller polls.
// - Data ready at measurement end is guaranteed when await-talk mode is on.
// - While serial poll is enabled, talking returns the status byte.
package srq_status_pkg;
    // Status byte bit positions
    localparam int BIT_DATA_READY  = 0;
    localparam int BIT_ERROR       = 2;
    localparam int BIT_FAILURE     = 3;
    localparam int BIT_LOCAL       = 4;
    localparam int BIT_OSCILLATOR_MISSING      = 5;
    localparam int BIT_RQS         = 6;
    // Mask bits that can enable a request
    localparam logic [7:0] MASK_USED_BITS = 8'h3d;
    localparam logic [7:0] MASK_RESET     = 8'h00;
    // Meta message codes from the bus decoder
    localparam logic [3:0] MSG_NONE    = 4'h0;
    localparam logic [3:0] MSG_TRIGGER = 4'h1;
    localparam logic [3:0] MSG_CLEAR   = 4'h2;
    localparam logic [3:0] MSG_REMOTE  = 4'h3;
    localparam logic [3:0] MSG_LOCAL   = 4'h4;
    localparam logic [3:0] MSG_LOCAL_CLEAR_LOCKOUT_MSG    = 4'h5;
    localparam logic [3:0] MSG_LOCKOUT = 4'h6;
    localparam logic [3:0] MSG_SRQ     = 4'h7;
    localparam logic [3:0] MSG_ABORT   = 4'h8;
    localparam logic [3:0] MSG_SPE     = 4'h9;
    localparam logic [3:0] MSG_SPD     = 4'ha;
    // Error code groups, split at 4.4 / 5.0
    localparam int ERR_LOW_W  = 8;
    localparam int ERR_HIGH_W = 4;
    // Panel state machine
    typedef enum logic [2:0] {
        ST_LOCAL   = 3'b001,
        ST_REMOTE  = 3'b010,
        ST_LOCKED  = 3'b100
    } panel_state_t;
endpackage

// >>> rtl/sticky_flag.sv
/*
 * One sticky event flag: set by a pulse, cleared by a pulse, set wins.
 * Assumes set and clear are synchronous one-cycle pulses.
 */
module sticky_flag (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    output logic      flag
);
    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clr_pulse) begin
            flag <= 1'b0;
        end
    end
endmodule

// >>> sim/bus_ctrl_model.sv
/* Behavioural bus system controller: meta messages, mask commands
   and serial polls. Assumes the bench calls its tasks. */
module bus_ctrl_model
    import srq_status_pkg::*;
(
    input  wire logic core_clk,
    output logic       msg_valid,
    output logic [3:0] msg_code,
    output logic       talk_addressed,
    output logic       status_sent,
    output logic       set_request_mask_cmd,
    output logic [7:0] mask_arg
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle lines; released codes show the inverse so stale values never pass
    initial begin
        {msg_valid, talk_addressed, status_sent, set_request_mask_cmd} = 4'h0;
        msg_code = 4'h0;
        mask_arg = 8'h00;
    end
    // One meta message, one cycle long
    task automatic send_msg(input logic [3:0] code);
        @(posedge core_clk);
        msg_valid <= 1'b1;
        msg_code  <= code;
        @(posedge core_clk);
        msg_valid <= 1'b0;
        msg_code  <= ~code;
    endtask
    // Mask goes out ahead of the condition it watches
    task automatic set_mask(input logic [7:0] m);
        @(posedge core_clk);
        set_request_mask_cmd <= 1'b1;
        mask_arg             <= m;
        @(posedge core_clk);
        set_request_mask_cmd <= 1'b0;
        mask_arg             <= ~m;
    endtask
    // Poll at any moment, prompt or slow by gap
    task automatic serial_poll(input int gap);
        send_msg(MSG_SPE);
        talk_addressed <= 1'b1;
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        status_sent <= 1'b1;
        @(posedge core_clk);
        status_sent    <= 1'b0;
        talk_addressed <= 1'b0;
    endtask
endmodule

// >>> sim/bus_service_request_status_test.sv
/* Self-checking bench for bus_service_request_status.
   Assumes the controller model and the bound checker. */
module bus_service_request_status_test
    import srq_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, nrst, dd_byte_valid, await_talk_address_mode, meas_done, data_taken;
    logic err_high_clr, failure_in, oscillator_missing, panel_key_valid, reset_local_key;
    logic msg_valid, talk_addressed, status_sent, set_request_mask_cmd, srq_out, serial_poll_active;
    logic remote_mode, lockout_active, blank_display, start_meas, abort_io, dd_cmd_valid, panel_cmd_valid;
    logic [3:0]           msg_code, err_high_set;
    logic [7:0]           dd_byte, mask_arg, panel_key, poll_status_byte, dd_cmd, panel_cmd, m, e;
    logic [ERR_LOW_W-1:0] err_low_set;
    logic                 osc_b, fail_b, loc_b, dr_b, req;
    logic [7:0]           corner [4] = '{8'h00, 8'h40, 8'hff, 8'h10};
    int                   err_total, num_checks;

    bus_ctrl_model ctl_u (.core_clk, .msg_valid, .msg_code, .talk_addressed, .status_sent,
        .set_request_mask_cmd, .mask_arg);
    bus_service_request_status dut_u (.core_clk, .nrst, .msg_valid, .msg_code, .talk_addressed,
        .status_sent, .dd_byte_valid, .dd_byte, .set_request_mask_cmd, .mask_arg, .await_talk_address_mode,
        .meas_done, .data_taken, .err_low_set, .err_high_set, .err_high_clr, .failure_in, .oscillator_missing,
        .panel_key_valid, .panel_key, .reset_local_key, .srq_out, .poll_status_byte, .serial_poll_active,
        .remote_mode, .lockout_active, .blank_display, .start_meas, .abort_io, .dd_cmd_valid, .dd_cmd,
        .panel_cmd_valid, .panel_cmd);

    // Free-running clock
    always #20 core_clk = ~core_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Status byte from its fields, weights 64/32/16/8/4/1
    function automatic logic [7:0] exp_status(logic rqs, osc, loc, fail, err, dr);
        return {1'b0, rqs, osc, loc, fail, err, 1'b0, dr};
    endfunction
    // Random command byte and panel key in one cycle; only one side passes
    task automatic keys(input logic rem);
        logic [7:0] d, p;
        d = 8'($urandom);
        p = 8'($urandom);
        @(posedge core_clk);
        {dd_byte_valid, panel_key_valid} <= 2'b11;
        dd_byte   <= d;
        panel_key <= p;
        @(posedge core_clk);
        {dd_byte_valid, panel_key_valid} <= 2'b00;
        #1;
        check({6'h00, dd_cmd_valid, panel_cmd_valid}, rem ? 8'h02 : 8'h01);
        check(rem ? dd_cmd : panel_cmd, rem ? d : p);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {core_clk, nrst, dd_byte_valid, meas_done, data_taken, err_high_clr, failure_in} = 7'h00;
        {oscillator_missing, panel_key_valid, reset_local_key, dd_byte, panel_key} = 19'h0;
        {err_low_set, err_high_set} = '0;
        await_talk_address_mode = 1'b1;
        void'($urandom(32'he784));
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        settle(1);
        check(poll_status_byte, 8'h10);
        $display("end reset");
        ctl_u.send_msg(MSG_TRIGGER);
        #1;
        check({6'h00, blank_display, start_meas}, 8'h03);
        $display("end trigger");
        // Random conditions against corner and random masks
        for (int i = 0; i < 12; i++) begin
            m = (i < 4) ? corner[i] : 8'($urandom);
            {osc_b, fail_b, loc_b, dr_b} = 4'($urandom);
            ctl_u.send_msg(loc_b ? MSG_LOCAL : MSG_REMOTE);
            ctl_u.set_mask(m); // Mask goes ahead of the conditions
            {oscillator_missing, failure_in, meas_done, data_taken} <= {osc_b, fail_b, dr_b, !dr_b};
            @(posedge core_clk);
            {meas_done, data_taken} <= 2'b00;
            settle(4);
            e = exp_status(1'b0, osc_b, loc_b, fail_b, 1'b0, dr_b);
            req = |(e & m & MASK_USED_BITS);
            check(poll_status_byte, e | {1'b0, req, 6'h00});
            check({7'h00, srq_out}, {7'h00, req});
        end
        $display("end mask");
        {oscillator_missing, failure_in} <= 2'b00;
        ctl_u.send_msg(MSG_LOCAL);
        ctl_u.set_mask(8'h10);
        settle(4);
        check({7'h00, srq_out}, 8'h01);
        ctl_u.serial_poll(2);
        #1;
        check({7'h00, srq_out}, 8'h00);
        settle(1);
        check({7'h00, poll_status_byte[BIT_RQS]}, 8'h00);
        ctl_u.send_msg(MSG_SPD);
        #1;
        check({7'h00, serial_poll_active}, 8'h00);
        $display("end poll");
        ctl_u.send_msg(MSG_REMOTE);
        keys(1'b1);
        ctl_u.send_msg(MSG_LOCKOUT);
        @(posedge core_clk);
        reset_local_key <= 1'b1;
        @(posedge core_clk);
        reset_local_key <= 1'b0;
        ctl_u.send_msg(MSG_SRQ);
        #1;
        check({6'h00, remote_mode, lockout_active}, 8'h03);
        ctl_u.send_msg(MSG_ABORT);
        #1;
        check({6'h00, abort_io, remote_mode}, 8'h03);
        ctl_u.send_msg(MSG_LOCAL_CLEAR_LOCKOUT_MSG);
        #1;
        check({6'h00, remote_mode, lockout_active}, 8'h00);
        keys(1'b0);
        $display("end panel");
        // Clear drops the low error group only
        @(posedge core_clk);
        err_low_set  <= ERR_LOW_W'(1) << $urandom_range(ERR_LOW_W - 1);
        err_high_set <= 4'h1 << $urandom_range(3);
        @(posedge core_clk);
        {err_low_set, err_high_set} <= '0;
        ctl_u.send_msg(MSG_CLEAR);
        settle(2);
        check({7'h00, poll_status_byte[BIT_ERROR]}, 8'h01);
        @(posedge core_clk);
        err_high_clr <= 1'b1;
        @(posedge core_clk);
        err_high_clr <= 1'b0;
        settle(2);
        check({7'h00, poll_status_byte[BIT_ERROR]}, 8'h00);
        $display("end errors");
        // Untalked with await mode off, a finished reading posts no data ready
        @(posedge core_clk);
        {await_talk_address_mode, data_taken} <= 2'b01;
        @(posedge core_clk);
        {meas_done, data_taken} <= 2'b10;
        @(posedge core_clk);
        meas_done <= 1'b0;
        settle(2);
        check({7'h00, poll_status_byte[BIT_DATA_READY]}, 8'h00);
        $display("end await");
        tally_and_finish();
    end
endmodule

// >>> sim/srq_status_sva.sv
/* Port checker for the service request and status block.
   Assumes it is bound to the top module; one clock domain. */
module srq_status_sva
    import srq_status_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       msg_valid,
    input wire logic [3:0] msg_code,
    input wire logic       status_sent,
    input wire logic       set_request_mask_cmd,
    input wire logic [7:0] mask_arg,
    input wire logic       reset_local_key,
    input wire logic       dd_byte_valid,
    input wire logic       srq_out,
    input wire logic [7:0] poll_status_byte,
    input wire logic       serial_poll_active,
    input wire logic       remote_mode,
    input wire logic       lockout_active,
    input wire logic       blank_display,
    input wire logic       start_meas,
    input wire logic       abort_io,
    input wire logic       dd_cmd_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] mask_reg;
    logic [2:0] idle_reg;
    // Shadow of the live mask bits; idle counts cycles with nothing enabled
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= 8'h00;
            idle_reg <= 3'h0;
        end else begin
            if (set_request_mask_cmd) mask_reg <= mask_arg & 8'h3d;
            if (set_request_mask_cmd || mask_reg != 8'h00) idle_reg <= 3'h0;
            else if (idle_reg != 3'h7) idle_reg <= idle_reg + 3'h1;
        end
    end
    sequence s_restart;
        blank_display && start_meas;
    endsequence
    sequence s_release;
        !srq_out ##1 !poll_status_byte[BIT_RQS];
    endsequence
    a_trigger_restart: assert property (msg_valid && msg_code == MSG_TRIGGER |=> s_restart)
        else $error("trigger did not restart");
    a_clear_restart: assert property (msg_valid && msg_code == MSG_CLEAR |=> s_restart)
        else $error("clear did not restart");
    a_remote_entry: assert property (msg_valid && msg_code == MSG_REMOTE |=> remote_mode)
        else $error("remote not entered");
    a_local_clear_lockout_msg_unlock: assert property (msg_valid && msg_code == MSG_LOCAL_CLEAR_LOCKOUT_MSG |=> !remote_mode && !lockout_active)
        else $error("lockout not cleared");
    a_lockout_hold: assert property (remote_mode && lockout_active && reset_local_key && !msg_valid |=> remote_mode)
        else $error("local key acted under lockout");
    a_local_dd_drop: assert property (!remote_mode && dd_byte_valid && !msg_valid |=> !dd_cmd_valid)
        else $error("command byte passed in local");
    a_abort_pulse: assert property (msg_valid && msg_code == MSG_ABORT |=> abort_io)
        else $error("abort not signalled");
    a_poll_mode: assert property (msg_valid && msg_code == MSG_SPE |=> serial_poll_active)
        else $error("poll mode not entered");
    a_poll_release: assert property (serial_poll_active && status_sent && srq_out |=> s_release)
        else $error("request not released by poll");
    a_zero_mask: assert property (idle_reg >= 3'h4 |-> !srq_out)
        else $error("request with empty mask");
    a_rqs_follows: assert property ($rose(srq_out) |-> ##[0:1] poll_status_byte[BIT_RQS])
        else $error("request without status flag");
endmodule

bind bus_service_request_status srq_status_sva chk_u (
    .core_clk, .nrst, .msg_valid, .msg_code, .status_sent, .set_request_mask_cmd, .mask_arg,
    .reset_local_key, .dd_byte_valid, .srq_out, .poll_status_byte, .serial_poll_active,
    .remote_mode, .lockout_active, .blank_display, .start_meas, .abort_io, .dd_cmd_valid
);
